/* File: inc/lbd_pkg.sv */
// Package for the local bus byte-lane decoder: constants, state and beat types.
// Assumes every user of it is clocked by the local bus clock.
package lbd_pkg;

  // Bus width settings that select 32-bit operation
  localparam logic [1:0] LBD_BW_DIRECT = 2'h2;
  localparam logic [1:0] LBD_BW_ENC    = 2'h3;

  // Byte-enable styles for the encoded width
  localparam logic LBD_STYLE_SIZE_ADDR = 1'h0;
  localparam logic LBD_STYLE_LINE      = 1'h1;

  // Lane enable patterns, active low, bit 3 is the top lane
  localparam logic [3:0] LBD_LANES_ALL  = 4'h0;
  localparam logic [3:0] LBD_LANES_NONE = 4'hf;

  // Size code of a cache-line fill in style 1
  localparam logic [1:0] LBD_SIZE_LINE = 2'h3;

  // Beats in a cache-line fill and the index of its last beat
  localparam int unsigned LBD_LINE_BEATS = 4;
  localparam logic [1:0]  LBD_LINE_LAST  = 2'h3;

  // Dword address width and value after reset
  localparam int unsigned LBD_ADDR_W   = 13;
  localparam logic [12:0] LBD_ADDR_RST = 13'h0000;

  // Burst tracking, Gray coded along idle -> burst -> line
  typedef enum logic [1:0] {
    LBD_IDLE  = 2'b00,
    LBD_BURST = 2'b01,
    LBD_LINE  = 2'b11
  } lbd_state_e;

  // One written beat handed to the shared memory
  typedef struct packed {
    logic [12:0] addr;
    logic [3:0]  lanes_n;
    logic [31:0] data;
  } lbd_beat_s;

endpackage

/* File: rtl/lbd_lane_decode.sv */
// Combinational translation of the four lane select pins into lane enables.
// Assumes the pins are already sampled on the local bus clock.
`timescale 1ns/1ps
module lbd_lane_decode
  import lbd_pkg::*;
(
  // Configuration
  input  wire logic [1:0] bus_width_sel,
  input  wire logic       byte_enable_style,
  // Pins
  input  wire logic [3:0] lane_select_n,
  // Result
  output logic [3:0]      lanes_n,
  output logic            line_fill,
  output logic            mode_32
);

  // Size in bits 3:2, low address in bits 1:0
  function automatic logic [3:0] style0_map(input logic [3:0] code);
    logic [3:0] r;
    r = LBD_LANES_NONE;
    case (code)
      4'h0: r = 4'h0;
      4'h1: r = 4'h8;
      4'h2: r = 4'hc;
      4'h3: r = 4'he;
      4'h4: r = 4'h7;
      4'h5: r = 4'hb;
      4'h6: r = 4'hd;
      4'h7: r = 4'he;
      4'h8: r = 4'h3;
      4'h9: r = 4'h9;
      4'ha: r = 4'hc;
      4'hb: r = 4'he;
      4'hc: r = 4'h1;
      4'hd: r = 4'h8;
      4'he: r = 4'hc;
      default: r = 4'he;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] style1_map(input logic [3:0] code);
    logic [3:0] r;
    r = LBD_LANES_ALL;
    case (code[3:2])
      2'h0: r = LBD_LANES_ALL;
      2'h1: r = ~(4'h8 >> code[1:0]);
      2'h2: r = code[1] ? 4'hc : 4'h3;
      default: r = LBD_LANES_ALL;
    endcase
    return r;
  endfunction

  wire         is_direct = (bus_width_sel == LBD_BW_DIRECT);
  wire         is_enc    = (bus_width_sel == LBD_BW_ENC);
  wire  [3:0]  enc_lanes = byte_enable_style ? style1_map(lane_select_n)
                                             : style0_map(lane_select_n);

  assign mode_32   = is_direct | is_enc;
  // Narrow widths belong to another block, so no lane is written here
  assign lanes_n   = is_direct ? lane_select_n
                   : is_enc    ? enc_lanes
                   : LBD_LANES_NONE;
  assign line_fill = is_enc & (byte_enable_style == LBD_STYLE_LINE)
                   & (lane_select_n[3:2] == LBD_SIZE_LINE);

endmodule

/* File: rtl/lbd_local_bus_byte_lane_decoder.sv */
// Byte-lane decoder for the 32-bit local bus port of a shared dual-port memory.
// Assumes all bus inputs are synchronous to clk, the local bus clock.
`timescale 1ns/1ps
module lbd_local_bus_byte_lane_decoder
  import lbd_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Configuration
  input  wire logic [1:0]          bus_width_sel,
  input  wire logic                byte_enable_style,
  input  wire logic                burst_wrap_off,
  // Local bus cycle qualifiers
  input  wire logic                addr_phase,
  input  wire logic [12:0]         start_addr,
  input  wire logic                data_phase,
  input  wire logic                wr_cycle,
  // Local bus pins
  input  wire logic [3:0]          lane_select_n,
  input  wire logic                final_beat_n,
  input  wire logic [31:0]         dq_in,
  // Toward the shared memory
  output lbd_pkg::lbd_beat_s       wr_beat,
  output logic                     wr_valid,
  output logic                     last_beat,
  output logic                     line_active,
  output logic                     mode_32
);
  import lbd_pkg::*;

  logic [3:0]  dec_lanes_n;
  logic        dec_line_fill;
  logic        dec_mode_32;

  lbd_lane_decode u_decode (
    .bus_width_sel     (bus_width_sel),
    .byte_enable_style (byte_enable_style),
    .lane_select_n     (lane_select_n),
    .lanes_n           (dec_lanes_n),
    .line_fill         (dec_line_fill),
    .mode_32           (dec_mode_32)
  );

  lbd_state_e  state_q;
  lbd_state_e  state_d;
  logic [12:0] addr_q;
  logic [12:0] addr_d;
  logic [1:0]  cnt_q;
  logic [1:0]  cnt_d;
  lbd_beat_s   beat_q;
  logic        valid_q;
  logic        last_q;
  logic        line_q;
  logic        mode_q;

  // Wrap keeps address bits 12:2 of the four-dword line, linear mode carries into the upper address
  function automatic logic [12:0] next_addr(input logic [12:0] a, input logic wrap);
    logic [12:0] inc;
    inc = a + 13'h0001;
    return wrap ? {a[12:2], inc[1:0]} : inc;
  endfunction

  wire        in_line    = (state_q == LBD_LINE);
  // A fill is recognised only on the first beat; later codes are don't-care
  wire        line_start = data_phase & dec_line_fill & (state_q == LBD_IDLE);
  wire        line_beat  = in_line | line_start;
  wire        line_end   = data_phase & line_beat & (cnt_q == LBD_LINE_LAST);
  wire        plain_end  = data_phase & ~line_beat & ~final_beat_n;
  wire        beat_end   = line_end | plain_end;
  wire        wr_accept  = data_phase & wr_cycle & dec_mode_32;
  wire  [3:0] beat_lanes = line_beat ? LBD_LANES_ALL : dec_lanes_n;
  wire        wrap_on    = line_beat & ~burst_wrap_off;

  always_comb
  begin
    state_d = state_q;
    addr_d  = addr_q;
    cnt_d   = cnt_q;
    if (addr_phase)
    begin
      state_d = LBD_IDLE;
      addr_d  = start_addr;
      cnt_d   = 2'h0;
    end
    else if (data_phase & dec_mode_32)
    begin
      addr_d = next_addr(addr_q, wrap_on);
      cnt_d  = line_beat ? cnt_q + 2'h1 : 2'h0;
      case (state_q)
        LBD_IDLE:  state_d = beat_end ? LBD_IDLE : (line_start ? LBD_LINE : LBD_BURST);
        LBD_BURST: state_d = beat_end ? LBD_IDLE : LBD_BURST;
        default:   state_d = beat_end ? LBD_IDLE : LBD_LINE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= LBD_IDLE;
      addr_q  <= LBD_ADDR_RST;
      cnt_q   <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      addr_q  <= addr_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      beat_q  <= '{addr: LBD_ADDR_RST, lanes_n: LBD_LANES_NONE, data: 32'h0000_0000};
      valid_q <= 1'b0;
      last_q  <= 1'b0;
      line_q  <= 1'b0;
      mode_q  <= 1'b0;
    end
    else
    begin
      if (wr_accept)
      begin
        beat_q <= '{addr: addr_q, lanes_n: beat_lanes, data: dq_in};
      end
      valid_q <= wr_accept;
      last_q  <= data_phase & dec_mode_32 & beat_end;
      line_q  <= (state_d == LBD_LINE);
      mode_q  <= dec_mode_32;
    end
  end

  assign wr_beat     = beat_q;
  assign wr_valid    = valid_q;
  assign last_beat   = last_q;
  assign line_active = line_q;
  assign mode_32     = mode_q;

  // Checks
  logic [2:0] line_len_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      line_len_q <= 3'h0;
    else if (addr_phase)
      line_len_q <= 3'h0;
    else if (data_phase & dec_mode_32 & line_beat)
      line_len_q <= line_end ? 3'h0 : line_len_q + 3'h1;
  end

  a_line_len_bound: assert property (@(posedge clk) disable iff (!resetn)
    line_len_q < 3'(LBD_LINE_BEATS)) else $error("line fill ran past four beats");

  a_direct_lanes: assert property (@(posedge clk) disable iff (!resetn)
    (wr_accept && bus_width_sel == LBD_BW_DIRECT && !line_beat)
    |=> (wr_valid && wr_beat.lanes_n == $past(lane_select_n)))
    else $error("direct mode lanes differ from pins");

  a_narrow_no_write: assert property (@(posedge clk) disable iff (!resetn)
    (!bus_width_sel[1]) |=> (!wr_valid && !mode_32)) else $error("write in narrow mode");

  a_line_all_lanes: assert property (@(posedge clk) disable iff (!resetn)
    (wr_accept && line_beat) |=> (wr_beat.lanes_n == LBD_LANES_ALL))
    else $error("line fill beat not full word");

  a_style0_single: assert property (@(posedge clk) disable iff (!resetn)
    (wr_accept && bus_width_sel == LBD_BW_ENC && !byte_enable_style
     && lane_select_n[3:2] == 2'h1)
    |=> ($countones(wr_beat.lanes_n) == 3)) else $error("style 0 byte write not one lane");

  a_style1_half: assert property (@(posedge clk) disable iff (!resetn)
    (wr_accept && bus_width_sel == LBD_BW_ENC && byte_enable_style
     && lane_select_n[3:2] == 2'h2 && !line_beat)
    |=> (wr_beat.lanes_n == ($past(lane_select_n[1]) ? 4'hc : 4'h3)))
    else $error("style 1 half word lanes wrong");

  a_line_ends_four: assert property (@(posedge clk) disable iff (!resetn)
    (line_start && !addr_phase) ##1 (data_phase && !addr_phase) [*3]
    |=> (last_beat && !line_active)) else $error("line fill did not end on fourth beat");

  a_wrap_addr: assert property (@(posedge clk) disable iff (!resetn)
    (data_phase && dec_mode_32 && line_beat && !addr_phase)
    |=> (addr_q[12:2] == ($past(burst_wrap_off) ? ($past(addr_q) + 13'h1) >> 2
                                                 : $past(addr_q[12:2]))))
    else $error("line fill address step wrong");

  a_data_latched: assert property (@(posedge clk) disable iff (!resetn)
    wr_accept |=> (wr_valid && wr_beat.data == $past(dq_in))) else $error("data not latched");

  c_direct_write: cover property (@(posedge clk) disable iff (!resetn)
    wr_accept && bus_width_sel == LBD_BW_DIRECT);
  c_style0_write: cover property (@(posedge clk) disable iff (!resetn)
    wr_accept && bus_width_sel == LBD_BW_ENC && !byte_enable_style);
  c_line_fill: cover property (@(posedge clk) disable iff (!resetn)
    line_end);
  c_plain_burst_end: cover property (@(posedge clk) disable iff (!resetn)
    plain_end && state_q == LBD_BURST);

endmodule

/* File: bench/lbd_bus_master_model.sv */
// Behavioural model of the local 32-bit processor that masters the bus.
// Assumes the caller enters each task just after a rising clock edge.
`timescale 1ns/1ps
module lbd_bus_master_model
  import lbd_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Bus toward the decoder
  output logic             addr_phase,
  output logic [12:0]      start_addr,
  output logic             data_phase,
  output logic             wr_cycle,
  output logic [3:0]       lane_select_n,
  output logic             final_beat_n,
  output logic [31:0]      dq_in
);
  initial
  begin
    addr_phase    = 1'b0;
    start_addr    = 13'h0000;
    data_phase    = 1'b0;
    wr_cycle      = 1'b0;
    lane_select_n = 4'hf;
    final_beat_n  = 1'b1;
    dq_in         = 32'h0000_0000;
  end

  // Address phase of one cycle; address is scrambled afterwards
  task automatic addr_cycle(input logic [12:0] a, input logic w);
    addr_phase = 1'b1;
    start_addr = a;
    wr_cycle   = w;
    @(posedge clk);
    #1;
    addr_phase = 1'b0;
    start_addr = ~a;
  endtask

  // Size bits on pins 3,2 and address bits on pins 1,0
  task automatic data_cycle(input logic [3:0] code, input logic [31:0] d, input logic fin_n);
    data_phase    = 1'b1;
    lane_select_n = code;
    dq_in         = d;
    final_beat_n  = fin_n;
    @(posedge clk);
    #1;
  endtask

  // Released lines show the inverse so stale values never look valid
  task automatic idle();
    data_phase    = 1'b0;
    lane_select_n = ~lane_select_n;
    dq_in         = ~dq_in;
    final_beat_n  = 1'b1;
  endtask
endmodule

/* File: bench/local_bus_byte_lane_decoder_bench.sv */
// Self-checking bench for the byte-lane decoder with a reference model.
// Assumes the bus master model drives every bus pin.
`timescale 1ns/1ps
module local_bus_byte_lane_decoder_bench;
  import lbd_pkg::*;
  // Lane tables, nibble n holds the enables of code n
  localparam logic [63:0] T0 = 64'hec81ec93edb7ec80;
  localparam logic [63:0] T1 = 64'h0000cc33edb70000;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [1:0]  bus_width_sel = LBD_BW_DIRECT;
  logic        byte_enable_style = 1'b0;
  logic        burst_wrap_off = 1'b0;
  logic        addr_phase, data_phase, wr_cycle, final_beat_n;
  logic [12:0] start_addr;
  logic [3:0]  lane_select_n;
  logic [31:0] dq_in;
  lbd_beat_s   wr_beat;
  logic        wr_valid, last_beat, line_active, mode_32;
  logic [31:0] seed = 32'h0000_004e;
  // Expected write beats of the reference model, oldest first
  logic [48:0] exp_q[$];
  int          errors = 0;
  int          cmp_count = 0;

  lbd_bus_master_model bfm (.clk(clk), .addr_phase(addr_phase), .start_addr(start_addr),
    .data_phase(data_phase), .wr_cycle(wr_cycle), .lane_select_n(lane_select_n),
    .final_beat_n(final_beat_n), .dq_in(dq_in));

  lbd_local_bus_byte_lane_decoder DUT (.clk(clk), .resetn(resetn),
    .bus_width_sel(bus_width_sel), .byte_enable_style(byte_enable_style),
    .burst_wrap_off(burst_wrap_off), .addr_phase(addr_phase), .start_addr(start_addr),
    .data_phase(data_phase), .wr_cycle(wr_cycle), .lane_select_n(lane_select_n),
    .final_beat_n(final_beat_n), .dq_in(dq_in), .wr_beat(wr_beat), .wr_valid(wr_valid),
    .last_beat(last_beat), .line_active(line_active), .mode_32(mode_32));

  initial
  begin
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [3:0] lanes(input logic [1:0] bw, input logic st, input logic [3:0] c);
    if (bw == LBD_BW_DIRECT)
      return c;
    return st ? T1[c*4 +: 4] : T0[c*4 +: 4];
  endfunction

  task automatic chk(input string name, input logic [48:0] seen, input logic [48:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // One transfer: address phase, then n back-to-back data phases, or four for a line fill
  task automatic xfer(input logic [1:0] bw, input logic st, input logic wo,
                      input logic [3:0] code, input logic wr, input int n);
    logic [12:0] a;
    logic [12:0] ea;
    logic [31:0] d;
    logic [3:0]  pin;
    logic        line;
    int          k;
    bus_width_sel     = bw;
    byte_enable_style = st;
    burst_wrap_off    = wo;
    line = bw == LBD_BW_ENC && st == LBD_STYLE_LINE && code[3:2] == LBD_SIZE_LINE;
    if (line)
      n = LBD_LINE_BEATS;
    d = nxt();
    a = d[12:0];
    bfm.addr_cycle(a, wr);
    for (k = 0; k < n; k++)
    begin
      d   = nxt();
      pin = (line && k > 0) ? d[7:4] : code;
      ea  = (line && !wo) ? {a[12:2], a[1:0] + k[1:0]} : a + k[12:0];
      if (wr && bw[1])
        exp_q.push_back({ea, lanes(bw, st, code), d});
      bfm.data_cycle(pin, d, line ? (k != 0) : (k != n - 1));
      chk("wr_valid", 49'(wr_valid), 49'(wr && bw[1]));
      if (wr && bw[1])
        chk("wr_beat", wr_beat, exp_q.pop_front());
      if (bw[1])
        chk("last_beat", 49'(last_beat), 49'(k == n - 1));
      chk("line_active", 49'(line_active), 49'(line && k < n - 1));
      chk("mode_32", 49'(mode_32), 49'(bw[1]));
    end
    bfm.idle();
  endtask

  initial
  begin
    repeat (50000) @(posedge clk);
    errors++;
    end_of_test();
  end

  initial
  begin
    logic [31:0] r;
    repeat (2) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk("wr_valid", 49'(wr_valid), 49'(1'b0));
    chk("wr_beat", wr_beat, {13'h0000, LBD_LANES_NONE, 32'h0000_0000});
    for (int b = 2; b < 4; b++)
      for (int s = 0; s < 2; s++)
        for (int c = 0; c < 16; c++)
        begin
          r = nxt();
          xfer(b[1:0], s[0], r[0], c[3:0], 1'b1, 1 + int'(r[1]));
        end
    for (int b = 0; b < 2; b++)
    begin
      r = nxt();
      xfer(b[1:0], r[0], 1'b0, r[7:4], 1'b1, 1);
    end
    xfer(LBD_BW_ENC, LBD_STYLE_LINE, 1'b0, 4'h0, 1'b0, 3);
    xfer(LBD_BW_ENC, LBD_STYLE_LINE, 1'b1, 4'hf, 1'b1, 1);
    end_of_test();
  end
endmodule
